// ---- include/acpc_pkg.sv ----
// package of constants and types for the converter conversion/power control
package acpc_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   // clock period in picoseconds (250 MHz)
   localparam int unsigned CLK_PERIOD_PS = 4000;
   // conversion phase length in ns; value is a plain default
   localparam int unsigned CONV_TIME_NS = 3000;
   // longest time, so rounded down to whole cycles, at least one
   localparam int unsigned CONV_CYCLES_RAW = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
   // width of the conversion cycle counter
   localparam int unsigned CNT_W = 12;

   // ****************************************************************
   // synchronised pin bundle: bit positions
   // ****************************************************************
   localparam int unsigned PIN_W = 6;
   localparam int unsigned PIN_START_N = 0;
   localparam int unsigned PIN_PD = 1;
   localparam int unsigned PIN_REF_PD = 2;
   localparam int unsigned PIN_BUF_PD = 3;
   localparam int unsigned PIN_CS_N = 4;
   localparam int unsigned PIN_RD_N = 5;
   // reset value of the bundle: strobes idle high, power-down pins low
   localparam logic [PIN_W-1:0] PIN_RESET = 6'h31;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      ACPC_ACQ,
      ACPC_CONV,
      ACPC_PDOWN
   } acpc_state_t;

   typedef struct packed {
      logic start_n;
      logic pd;
      logic ref_pd;
      logic buf_pd;
      logic cs_n;
      logic rd_n;
   } acpc_pins_t;

   typedef struct packed {
      acpc_state_t st;
      logic [CNT_W-1:0] cnt;
      logic start_prev;
      logic busy;
      logic low_power;
      logic powered_down;
      logic done;
      logic ref_core_on;
      logic ref_buffer_on;
      logic temp_en;
      logic bus_en;
   } acpc_regs_t;

endpackage

// ---- rtl/acpc_ctrl.sv ----
// conversion start and power-state control of the sampling converter
`timescale 1ns/100ps
module acpc_ctrl
   import acpc_pkg::*;
#(
   parameter int unsigned CONV_LEN = CONV_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic conversion_start_n,
   input wire logic powerdown_pin,
   input wire logic ref_core_powerdown,
   input wire logic ref_buffer_powerdown,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic cfg_powerdown_sel,
   input wire logic cfg_powerdown,
   output logic busy_q,
   output logic conv_done_q,
   output logic low_power_q,
   output logic powered_down_q,
   output logic ref_core_on_q,
   output logic ref_buffer_on_q,
   output logic temp_sensor_en_q,
   output logic bus_enable_q
);

   // ****************************************************************
   // pin synchronisation
   // ****************************************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_lvl;
   acpc_pins_t pins;

   // all pins come from the host's domain, so each one is filtered
   always_comb begin
      pin_raw = '0;
      pin_raw[PIN_START_N] = conversion_start_n;
      pin_raw[PIN_PD] = powerdown_pin;
      pin_raw[PIN_REF_PD] = ref_core_powerdown;
      pin_raw[PIN_BUF_PD] = ref_buffer_powerdown;
      pin_raw[PIN_CS_N] = cs_n;
      pin_raw[PIN_RD_N] = rd_n;
   end

   acpc_pin_sync #(
      .W(PIN_W),
      .INIT(PIN_RESET)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .pin(pin_raw),
      .level_q(pin_lvl)
   );

   // unpack the filtered levels into the carrier struct
   always_comb begin
      pins.start_n = pin_lvl[PIN_START_N];
      pins.pd = pin_lvl[PIN_PD];
      pins.ref_pd = pin_lvl[PIN_REF_PD];
      pins.buf_pd = pin_lvl[PIN_BUF_PD];
      pins.cs_n = pin_lvl[PIN_CS_N];
      pins.rd_n = pin_lvl[PIN_RD_N];
   end

   // ****************************************************************
   // request decode
   // ****************************************************************
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_LEN - 1);

   logic start_fall;
   logic pd_req;
   logic conv_last;
   acpc_regs_t r_q;
   acpc_regs_t r_d;

   // edge on the filtered level only; strobes take no part in it
   assign start_fall = r_q.start_prev & ~pins.start_n;
   // config selection makes the pin a don't-care
   assign pd_req = cfg_powerdown_sel ? cfg_powerdown : pins.pd;
   assign conv_last = (r_q.st == ACPC_CONV) && (r_q.cnt == CNT_LAST);

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   // power-down is sampled in a conversion only on its last cycle, so a request
   // that arrives mid-conversion simply waits for the last cycle
   always_comb begin
      r_d = r_q;
      r_d.start_prev = pins.start_n;
      r_d.done = 1'b0;
      unique case (r_q.st)
         ACPC_ACQ: begin
            if (start_fall) begin
               r_d.st = ACPC_CONV;
               r_d.cnt = '0;
            end else if (pd_req) begin
               r_d.st = ACPC_PDOWN;
            end
         end
         ACPC_CONV: begin
            // further start edges are not looked at here; power-down only on the last cycle
            if (conv_last) begin
               r_d.done = 1'b1;
               r_d.cnt = '0;
               if (pd_req) begin
                  r_d.st = ACPC_PDOWN;
               end else begin
                  r_d.st = ACPC_ACQ;
               end
            end else begin
               r_d.cnt = r_q.cnt + CNT_W'(1);
            end
         end
         ACPC_PDOWN: begin
            // start edges while powered down are dropped
            if (!pd_req) begin
               r_d.st = ACPC_ACQ;
            end
         end
      endcase
      r_d.busy = (r_d.st == ACPC_CONV);
      r_d.low_power = (r_d.st == ACPC_ACQ);
      r_d.powered_down = (r_d.st == ACPC_PDOWN);
      // reference pieces follow their own pins, independent of state
      r_d.ref_core_on = ~pins.ref_pd;
      r_d.ref_buffer_on = ~pins.buf_pd;
      r_d.temp_en = ~pins.ref_pd & ~pins.buf_pd;
      // host interface never gated by acquisition or power-down
      r_d.bus_en = ~pins.cs_n & ~pins.rd_n;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         r_q.st <= ACPC_ACQ;
         r_q.cnt <= '0;
         r_q.start_prev <= 1'b1;
         r_q.busy <= 1'b0;
         r_q.low_power <= 1'b1;
         r_q.powered_down <= 1'b0;
         r_q.done <= 1'b0;
         r_q.ref_core_on <= 1'b1;
         r_q.ref_buffer_on <= 1'b1;
         r_q.temp_en <= 1'b1;
         r_q.bus_en <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // ****************************************************************
   // outputs, all straight from flip-flops
   // ****************************************************************
   assign busy_q = r_q.busy;
   assign conv_done_q = r_q.done;
   assign low_power_q = r_q.low_power;
   assign powered_down_q = r_q.powered_down;
   assign ref_core_on_q = r_q.ref_core_on;
   assign ref_buffer_on_q = r_q.ref_buffer_on;
   assign temp_sensor_en_q = r_q.temp_en;
   assign bus_enable_q = r_q.bus_en;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // a start edge seen in acquisition opens a conversion
   sequence s_start_in_acq;
      start_fall && (r_q.st == ACPC_ACQ);
   endsequence

   // a conversion runs its last cycle and then leaves
   sequence s_conv_end;
      busy_q && conv_last;
   endsequence

   a_start_begins_conv: assert property (
      s_start_in_acq |=> busy_q && !low_power_q && (r_q.cnt == '0))
      else $error("start edge did not begin a conversion");

   a_start_any_strobe: assert property (
      s_start_in_acq and (!pins.cs_n && !pins.rd_n) |=> busy_q)
      else $error("start edge lost while strobes active");

   a_conv_no_abort: assert property (
      busy_q && !conv_last |=> busy_q && (r_q.cnt == $past(r_q.cnt) + 1'b1))
      else $error("conversion restarted or aborted");

   a_conv_end_done: assert property (
      s_conv_end |=> !busy_q && conv_done_q ##1 !conv_done_q)
      else $error("conversion end not flagged for one cycle");

   a_pd_deferred: assert property (
      s_conv_end and pd_req |=> powered_down_q && !low_power_q)
      else $error("deferred power-down not taken at conversion end");

   a_pd_not_early: assert property (
      busy_q && !conv_last |=> !powered_down_q)
      else $error("power-down entered during a conversion");

   a_low_power_acq: assert property (
      s_conv_end and !pd_req |=> low_power_q && !busy_q)
      else $error("no low-current state after conversion");

   a_pd_enter: assert property (
      (r_q.st == ACPC_ACQ) && !start_fall && pd_req |=> powered_down_q)
      else $error("power-down request not obeyed");

   a_pd_cfg_path: assert property (
      (r_q.st == ACPC_ACQ) && !start_fall && cfg_powerdown_sel
         && cfg_powerdown |=> powered_down_q)
      else $error("configured power-down not obeyed");

   a_pin_ignored: assert property (
      powered_down_q && cfg_powerdown_sel && !cfg_powerdown
         |=> !powered_down_q)
      else $error("power-down pin acted under config control");

   a_ref_follow: assert property (
      ##1 (ref_core_on_q == !$past(pins.ref_pd))
         && (ref_buffer_on_q == !$past(pins.buf_pd)))
      else $error("reference power state does not follow its pin");

   a_temp_gate: assert property (
      temp_sensor_en_q |-> ref_core_on_q && ref_buffer_on_q)
      else $error("temperature sensor on with reference powered down");

   a_bus_active: assert property (
      !pins.cs_n && !pins.rd_n |=> bus_enable_q)
      else $error("host interface gated by power state");

endmodule

// ---- rtl/acpc_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module acpc_pin_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level_q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // first stage feeds only the second; a change counts once 2 and 3 agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         level_q <= INIT;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               level_q[i] <= s3_q[i];
            end
         end
      end
   end

endmodule

// ---- tb/acpc_ctrl_test.sv ----
// self-checking bench for the conversion and power control block
`timescale 1ns/100ps
module acpc_ctrl_test;
   import acpc_pkg::*;
   localparam int LEN = 12;
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
   bad_count++; $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
   logic clk = 1'b0;
   logic rst = 1'b1;
   int bad_count = 0;
   int comparisons = 0;
   int len;
   acpc_pins_t pins;
   logic cfg_sel, cfg_pd, busy_q, conv_done_q, low_power_q, powered_down_q;
   logic ref_core_on_q, ref_buffer_on_q, temp_sensor_en_q, bus_enable_q;

   always #2 clk = ~clk;

   acpc_host_model acpc_host_model_inst (.clk(clk), .pins(pins),
      .cfg_sel(cfg_sel), .cfg_pd(cfg_pd));

   acpc_ctrl #(.CONV_LEN(LEN)) acpc_ctrl_inst (.clk(clk), .rst(rst),
      .conversion_start_n(pins.start_n), .powerdown_pin(pins.pd),
      .ref_core_powerdown(pins.ref_pd), .ref_buffer_powerdown(pins.buf_pd),
      .cs_n(pins.cs_n), .rd_n(pins.rd_n), .cfg_powerdown_sel(cfg_sel),
      .cfg_powerdown(cfg_pd), .busy_q(busy_q), .conv_done_q(conv_done_q),
      .low_power_q(low_power_q), .powered_down_q(powered_down_q),
      .ref_core_on_q(ref_core_on_q), .ref_buffer_on_q(ref_buffer_on_q),
      .temp_sensor_en_q(temp_sensor_en_q), .bus_enable_q(bus_enable_q));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic stop_test;
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // sample just after the edge so that edge's updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // bounded waits: a stuck busy ends the run as a failure
   task automatic measure(output int n);
      int i;
      n = 0;
      for (i = 0; i < 40 && busy_q !== 1'b1; i++) tick(1);
      for (i = 0; i < 100 && busy_q === 1'b1; i++) begin
         tick(1);
         n++;
      end
      if (i == 100 || n == 0) begin
         bad_count++;
         stop_test();
      end
      `CHECK(conv_done_q, 1'b1)
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      `CHECK(low_power_q, 1'b1)
      `CHECK(busy_q, 1'b0)
      // once with strobes idle, once with them active
      for (int k = 0; k < 2; k++) begin
         acpc_host_model_inst.set_bus(k == 0, k == 0);
         tick(6);
         `CHECK(bus_enable_q, k == 1)
         fork
            acpc_host_model_inst.start_pulse(6);
            measure(len);
         join
         `CHECK(len, LEN)
         tick(1);
         `CHECK(low_power_q, 1'b1)
         `CHECK(conv_done_q, 1'b0)
      end
      // second start edge inside a running conversion is dropped
      fork
         acpc_host_model_inst.start_pulse(3);
         measure(len);
         begin
            tick(9);
            acpc_host_model_inst.start_pulse(3);
         end
      join
      `CHECK(len, LEN)
      tick(12);
      `CHECK(busy_q, 1'b0)
      // power-down in mid-conversion waits for the end
      fork
         acpc_host_model_inst.start_pulse(3);
         measure(len);
         begin
            tick(8);
            acpc_host_model_inst.set_pd(1'b1);
         end
      join
      `CHECK(len, LEN)
      `CHECK(powered_down_q, 1'b1)
      acpc_host_model_inst.start_pulse(3);
      tick(8);
      `CHECK(busy_q, 1'b0)
      `CHECK(low_power_q, 1'b0)
      `CHECK(bus_enable_q, 1'b1)
      acpc_host_model_inst.set_pd(1'b0);
      tick(6);
      `CHECK(powered_down_q, 1'b0)
      `CHECK(low_power_q, 1'b1)
      // configuration control: pin tied high must be ignored
      acpc_host_model_inst.set_cfg(1'b1, 1'b0);
      acpc_host_model_inst.set_pd(1'b1);
      tick(6);
      `CHECK(powered_down_q, 1'b0)
      acpc_host_model_inst.set_cfg(1'b1, 1'b1);
      tick(2);
      `CHECK(powered_down_q, 1'b1)
      acpc_host_model_inst.set_cfg(1'b1, 1'b0);
      tick(2);
      `CHECK(powered_down_q, 1'b0)
      // all four reference power-down combinations
      for (int k = 0; k < 4; k++) begin
         acpc_host_model_inst.set_ref(k[1], k[0]);
         tick(6);
         `CHECK(ref_core_on_q, ~k[1])
         `CHECK(ref_buffer_on_q, ~k[0])
         `CHECK(temp_sensor_en_q, k == 0)
      end
      stop_test();
   end
endmodule

// ---- tb/acpc_host_model.sv ----
// host model that drives the start, power-down, reference and bus pins
`timescale 1ns/100ps
module acpc_host_model
   import acpc_pkg::*;
(
   input wire logic clk,
   output acpc_pins_t pins,
   output logic cfg_sel,
   output logic cfg_pd
);
   // ************************************************************
   // pin drivers, all changed by non-blocking at the rising edge
   // ************************************************************
   // idle levels: strobes high, power-down pins low
   initial begin
      pins = '{start_n: 1'b1, pd: 1'b0, ref_pd: 1'b0, buf_pd: 1'b0,
               cs_n: 1'b1, rd_n: 1'b1};
      cfg_sel = 1'b0;
      cfg_pd = 1'b0;
   end

   // low phase long enough to pass the filter; high phase left to caller
   task automatic start_pulse(input int low_cyc);
      @(posedge clk) pins.start_n <= 1'b0;
      repeat (low_cyc) @(posedge clk);
      pins.start_n <= 1'b1;
   endtask

   task automatic set_pd(input logic v);
      @(posedge clk) pins.pd <= v;
   endtask

   // both high selects a reference driven straight onto the node
   task automatic set_ref(input logic core, input logic buff);
      @(posedge clk) pins.ref_pd <= core;
      pins.buf_pd <= buff;
   endtask

   task automatic set_bus(input logic cs, input logic rd);
      @(posedge clk) pins.cs_n <= cs;
      pins.rd_n <= rd;
   endtask

   // pin is ignored while sel is high; the caller raises it just after setting sel
   task automatic set_cfg(input logic sel, input logic pd);
      @(posedge clk) cfg_sel <= sel;
      cfg_pd <= pd;
   endtask
endmodule
